// >>> include/rcsr_defines.svh
// timing constants and reset values of the radio shutdown/reset block
`ifndef RCSR_DEFINES_SVH
`define RCSR_DEFINES_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define RCSR_CLK_PERIOD_NS      50
`define RCSR_POR_RELEASE_NS     200
// least time, so round up to whole clock cycles
`define RCSR_POR_RELEASE_CYCLES \
    ((`RCSR_POR_RELEASE_NS + `RCSR_CLK_PERIOD_NS - 1) / `RCSR_CLK_PERIOD_NS)
`define RCSR_POR_COUNT_WIDTH    4

// ----------------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------------
`define RCSR_WAKE_WIDTH         16
`define RCSR_WAKE_INTERVAL_DEF  16'h0020
`define RCSR_OFF                1'b0
`define RCSR_ON                 1'b1
`define RCSR_OE_N_TRISTATE      1'b1
`define RCSR_OE_N_DRIVE         1'b0

`endif

// >>> include/rcsr_pkg.sv
// types shared by the radio shutdown/reset block
`include "rcsr_defines.svh"

package rcsr_pkg;

    // ------------------------------------------------------------------------
    // power sequencing states and link low-power modes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        st_por_hold,
        st_por_release,
        st_active,
        st_low_power,
        st_shutdown
    } rcsr_state_type;

    typedef enum logic [1:0]
    {
        mode_active,
        mode_sniff,
        mode_hold,
        mode_park
    } rcsr_link_mode_type;

    // ------------------------------------------------------------------------
    // whole state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        rcsr_state_type                    state;
        logic                              enable_meta;
        logic                              enable_sync;
        logic [`RCSR_POR_COUNT_WIDTH-1:0]  por_count;
        logic                              slow_sample;
        logic                              slow_prev;
        logic                              core_reset;
        logic                              core_supply;
        logic                              rf_supply;
        logic                              pins_oe_n;
        logic                              inputs_enabled;
        logic                              slow_clock_select;
        logic                              rf_tx_on;
        logic                              rf_rx_on;
        logic                              rf_pll_on;
        logic                              rf_pa_on;
        logic                              wake_pulse;
        logic                              timer_start;
    } rcsr_top_state_type;

    // ------------------------------------------------------------------------
    // whole state of the wake timer
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        logic [`RCSR_WAKE_WIDTH-1:0]  count;
        logic                         running;
        logic                         expired;
    } rcsr_timer_state_type;

endpackage : rcsr_pkg

// >>> include/rcsr_timer_if.sv
// carrier between the sequencer and its slow-clock wake timer
`timescale 1ns/1ps
`default_nettype none
`include "rcsr_defines.svh"

interface rcsr_timer_if;
    logic                         start;
    logic                         stop;
    logic                         slow_tick;
    logic [`RCSR_WAKE_WIDTH-1:0]  interval;
    logic                         expired;

    modport control (output start, output stop, output slow_tick,
                     output interval, input expired);
    modport timer   (input start, input stop, input slow_tick,
                     input interval, output expired);
endinterface : rcsr_timer_if

`default_nettype wire

// >>> logic/rcsr_wake_timer.sv
// slow-clock wake timer used during sniff, hold and park
`timescale 1ns/1ps
`default_nettype none
`include "rcsr_defines.svh"

module rcsr_wake_timer
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // control from the sequencer
    rcsr_timer_if.timer        tmr
);
    import rcsr_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    localparam rcsr_timer_state_type TIMER_RESET = '{default: '0};

    rcsr_timer_state_type  cur_reg;
    rcsr_timer_state_type  cur_next;

    // counts slow ticks only; the fast clock just samples them
    always_comb
    begin
        cur_next         = cur_reg;
        cur_next.expired = `RCSR_OFF;
        if (tmr.stop)
        begin
            cur_next.running = `RCSR_OFF;
        end
        else if (tmr.start)
        begin
            cur_next.count   = '0;
            cur_next.running = `RCSR_ON;
        end
        else if (cur_reg.running && tmr.slow_tick)
        begin
            // zero wakes on the first tick, not never
            if ((`RCSR_WAKE_WIDTH+1)'(cur_reg.count) + 1'b1 >=
                (`RCSR_WAKE_WIDTH+1)'(tmr.interval))
            begin
                cur_next.expired = `RCSR_ON;   // R7
                cur_next.running = `RCSR_OFF;
            end
            else
            begin
                cur_next.count = cur_reg.count + 1'b1;
            end
        end
    end

    // register the state
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cur_reg <= TIMER_RESET;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign tmr.expired = cur_reg.expired;

endmodule : rcsr_wake_timer

`default_nettype wire

// >>> logic/rcsr_top.sv
// power-on reset, shutdown, low-power wake and rf gating for the radio core
//
// Contract
// R1: core reset stays asserted while radio_power_enable is low.
// R2: core reset releases only after radio_power_enable has gone high.
// R3: asserted reset forces all core state to fixed initial values.
// R4: shutdown turns rf and core supplies off, keeps io supply.
// R5: in shutdown with io supply present, outputs tristate, inputs disabled.
// R6: leaving shutdown is a full power-up; nothing is retained.
// R7: sniff/hold/park run from slow clock and self-wake after interval.
// R8: packet logic switches rf sections on and off per packet.
// R9: power enable is synchronised before reset releases on one edge.
`timescale 1ns/1ps
`default_nettype none
`include "rcsr_defines.svh"

module rcsr_top
#(
    parameter int WAKE_WIDTH = `RCSR_WAKE_WIDTH
)
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // host power control
    input  wire logic                       radio_power_enable,
    input  wire logic                       shutdown_request,
    input  wire logic                       io_supply,
    // slow oscillator and link low-power control
    input  wire logic                       slow_clock_input,
    input  wire rcsr_pkg::rcsr_link_mode_type link_mode_request,
    input  wire logic [WAKE_WIDTH-1:0]      wake_interval,
    // packet timing from the baseband
    input  wire logic                       tx_packet_active,
    input  wire logic                       rx_packet_active,
    // core power and reset
    output logic                            core_reset,
    output logic                            core_supply_enable,
    output logic                            rf_supply_enable,
    output logic                            core_clock_enable,
    output logic                            slow_clock_select,
    output logic                            wake_event,
    // pad control
    output logic                            pins_output_enable_n,
    output logic                            pins_input_enable,
    // rf section power
    output logic                            rf_tx_power_on,
    output logic                            rf_rx_power_on,
    output logic                            rf_pll_power_on,
    output logic                            rf_pa_power_on,
    // observation
    output rcsr_pkg::rcsr_state_type        power_state
);
    import rcsr_pkg::*;

    // ------------------------------------------------------------------------
    // reset image of the whole state
    // ------------------------------------------------------------------------
    // the single defined start point, constants only
    localparam rcsr_top_state_type TOP_RESET = '{
        state:             st_por_hold,
        enable_meta:       `RCSR_OFF,
        enable_sync:       `RCSR_OFF,
        por_count:         '0,
        slow_sample:       `RCSR_OFF,
        slow_prev:         `RCSR_OFF,
        core_reset:        `RCSR_ON,
        core_supply:       `RCSR_OFF,
        rf_supply:         `RCSR_OFF,
        pins_oe_n:         `RCSR_OE_N_TRISTATE,
        inputs_enabled:    `RCSR_OFF,
        slow_clock_select: `RCSR_OFF,
        rf_tx_on:          `RCSR_OFF,
        rf_rx_on:          `RCSR_OFF,
        rf_pll_on:         `RCSR_OFF,
        rf_pa_on:          `RCSR_OFF,
        wake_pulse:        `RCSR_OFF,
        timer_start:       `RCSR_OFF
    };

    localparam logic [`RCSR_POR_COUNT_WIDTH-1:0] POR_LAST =
        `RCSR_POR_COUNT_WIDTH'(`RCSR_POR_RELEASE_CYCLES - 1);

    rcsr_top_state_type  cur_reg;
    rcsr_top_state_type  cur_next;
    logic                slow_tick;

    rcsr_timer_if        timer_link ();

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // power-up image for enable low, shutdown entry and exit, and illegal states
    function automatic rcsr_top_state_type power_up_image
    (
        input rcsr_top_state_type src
    );
        rcsr_top_state_type img;
        img             = TOP_RESET;
        // synchroniser and slow clock sampling keep running across reset
        img.enable_meta = src.enable_meta;
        img.enable_sync = src.enable_sync;
        img.slow_sample = src.slow_sample;
        img.slow_prev   = src.slow_prev;
        return img;
    endfunction : power_up_image

    // ------------------------------------------------------------------------
    // slow clock tick
    // ------------------------------------------------------------------------
    // the sampled slow oscillator's rising edge is a one-cycle enable
    assign slow_tick = cur_reg.slow_sample && !cur_reg.slow_prev;

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        cur_next             = cur_reg;
        cur_next.wake_pulse  = `RCSR_OFF;
        cur_next.timer_start = `RCSR_OFF;
        // two-stage sync; only enable_sync is read below
        cur_next.enable_meta = radio_power_enable;             // R9
        cur_next.enable_sync = cur_reg.enable_meta;            // R9
        cur_next.slow_sample = slow_clock_input;
        cur_next.slow_prev   = cur_reg.slow_sample;

        if (!cur_reg.enable_sync && cur_reg.state != st_por_hold)
        begin
            // power enable low: back to the power-up image at once
            cur_next = power_up_image(cur_next);               // R1 R3
        end
        else
        begin
            case (cur_reg.state)
                st_por_hold:
                begin
                    // reset stays asserted until the synced enable is high
                    cur_next.core_reset = `RCSR_ON;            // R1
                    cur_next.por_count  = '0;
                    if (cur_reg.enable_sync)
                    begin
                        cur_next.state       = st_por_release; // R2
                        cur_next.core_supply = `RCSR_ON;
                        cur_next.rf_supply   = `RCSR_ON;
                    end
                end
                st_por_release:
                begin
                    // supplies settle before reset lets go on one edge
                    if (cur_reg.por_count == POR_LAST)
                    begin
                        cur_next.state          = st_active;
                        cur_next.core_reset     = `RCSR_OFF;   // R2 R9
                        cur_next.pins_oe_n      = `RCSR_OE_N_DRIVE;
                        cur_next.inputs_enabled = `RCSR_ON;
                    end
                    else
                    begin
                        cur_next.por_count = cur_reg.por_count + 1'b1;
                    end
                end
                st_active:
                begin
                    // rf blocks follow the packet windows
                    cur_next.rf_tx_on  = tx_packet_active;     // R8
                    cur_next.rf_pa_on  = tx_packet_active;     // R8
                    cur_next.rf_rx_on  = rx_packet_active;     // R8
                    cur_next.rf_pll_on = tx_packet_active ||
                                         rx_packet_active;     // R8
                    if (shutdown_request)
                    begin
                        cur_next       = power_up_image(cur_next);
                        cur_next.state = st_shutdown;          // R4 R5
                    end
                    else if (link_mode_request != mode_active)
                    begin
                        // rf off, slow clock takes over
                        cur_next.state             = st_low_power; // R7
                        cur_next.slow_clock_select = `RCSR_ON;     // R7
                        cur_next.timer_start       = `RCSR_ON;     // R7
                        cur_next.rf_supply         = `RCSR_OFF;
                        cur_next.rf_tx_on          = `RCSR_OFF;
                        cur_next.rf_rx_on          = `RCSR_OFF;
                        cur_next.rf_pll_on         = `RCSR_OFF;
                        cur_next.rf_pa_on          = `RCSR_OFF;
                    end
                end
                st_low_power:
                begin
                    // wake on the timer, or early when the mode drops
                    if (timer_link.expired ||
                        link_mode_request == mode_active)
                    begin
                        cur_next.state             = st_active;
                        cur_next.slow_clock_select = `RCSR_OFF; // R7
                        cur_next.rf_supply         = `RCSR_ON;
                        cur_next.wake_pulse        = timer_link.expired;
                    end
                    else if (shutdown_request)
                    begin
                        cur_next       = power_up_image(cur_next);
                        cur_next.state = st_shutdown;           // R4
                    end
                end
                st_shutdown:
                begin
                    // core and rf dark, io stays up, pads released
                    cur_next.core_supply    = `RCSR_OFF;        // R4
                    cur_next.rf_supply      = `RCSR_OFF;        // R4
                    cur_next.core_reset     = `RCSR_ON;
                    cur_next.pins_oe_n      = `RCSR_OE_N_TRISTATE; // R5
                    cur_next.inputs_enabled = `RCSR_OFF;        // R5
                    if (!shutdown_request)
                    begin
                        // full power-up path, nothing kept
                        cur_next = power_up_image(cur_next);    // R6
                    end
                end
                default:
                begin
                    cur_next = power_up_image(cur_next);        // R3
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cur_reg <= TOP_RESET;                               // R3
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    // ------------------------------------------------------------------------
    // wake timer
    // ------------------------------------------------------------------------
    // timer stopped outside low power, so a stale count never wakes early
    assign timer_link.start     = cur_reg.timer_start;
    assign timer_link.stop      = (cur_reg.state != st_low_power) &&
                                  !cur_reg.timer_start;
    assign timer_link.slow_tick = slow_tick;                    // R7
    assign timer_link.interval  = `RCSR_WAKE_WIDTH'(wake_interval);

    rcsr_wake_timer u_wake_timer
    (
        .clk   (clk),
        .reset (reset),
        .tmr   (timer_link.timer)
    );

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign core_reset           = cur_reg.core_reset;
    assign core_supply_enable   = cur_reg.core_supply;
    assign rf_supply_enable     = cur_reg.rf_supply;
    assign core_clock_enable    = !cur_reg.slow_clock_select &&
                                  !cur_reg.core_reset;
    assign slow_clock_select    = cur_reg.slow_clock_select;
    assign wake_event           = cur_reg.wake_pulse;
    // without io supply nothing can be driven anyway
    assign pins_output_enable_n = cur_reg.pins_oe_n || !io_supply; // R5
    assign pins_input_enable    = cur_reg.inputs_enabled && io_supply;
    assign rf_tx_power_on       = cur_reg.rf_tx_on;
    assign rf_rx_power_on       = cur_reg.rf_rx_on;
    assign rf_pll_power_on      = cur_reg.rf_pll_on;
    assign rf_pa_power_on       = cur_reg.rf_pa_on;
    assign power_state          = cur_reg.state;

endmodule : rcsr_top

`default_nettype wire

// >>> testbench/rcsr_top_checker.sv
// concurrent checks on the ports of the radio power and reset sequencer
`timescale 1ns/1ps
`default_nettype none

module rcsr_top_checker
(
    // clock and reset
    input wire logic                         clk,
    input wire logic                         reset,
    // host and baseband inputs
    input wire logic                         radio_power_enable,
    input wire logic                         shutdown_request,
    input wire logic                         io_supply,
    input wire rcsr_pkg::rcsr_link_mode_type link_mode_request,
    input wire logic                         tx_packet_active,
    input wire logic                         rx_packet_active,
    // power, reset and pad outputs
    input wire logic                         core_reset,
    input wire logic                         core_supply_enable,
    input wire logic                         rf_supply_enable,
    input wire logic                         slow_clock_select,
    input wire logic                         wake_event,
    input wire logic                         pins_output_enable_n,
    input wire logic                         pins_input_enable,
    // rf sections and state
    input wire logic                         rf_tx_power_on,
    input wire logic                         rf_rx_power_on,
    input wire logic                         rf_pll_power_on,
    input wire logic                         rf_pa_power_on,
    input wire rcsr_pkg::rcsr_state_type     power_state
);
    import rcsr_pkg::*;

    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // hold reached, then enable high through the count
    sequence power_up;
        !radio_power_enable [*2] ##1 radio_power_enable [*7];
    endsequence

    // active, no request to leave, enable settled
    sequence stay_active;
        power_state == st_active && !shutdown_request &&
        link_mode_request == mode_active && $past(radio_power_enable, 2);
    endsequence

    // two synchronised low samples always land in reset
    a_por_hold_low: assert property (!radio_power_enable ##1
        !radio_power_enable |-> ##2 core_reset)
        else $error("core reset not held while enable low");
    a_release_order: assert property (power_up |->
        core_reset ##1 !core_reset)
        else $error("core reset released at the wrong edge");
    a_shutdown_entry: assert property (power_state == st_active &&
        shutdown_request && $past(radio_power_enable, 2) |=>
        power_state == st_shutdown && core_reset && pins_output_enable_n)
        else $error("shutdown entry wrong");
    a_shutdown_power: assert property (power_state == st_shutdown [*2]
        |-> !core_supply_enable && !rf_supply_enable)
        else $error("supplies still on in shutdown");
    a_shutdown_pads: assert property (power_state == st_shutdown ||
        !io_supply |-> pins_output_enable_n && !pins_input_enable)
        else $error("pads not released in shutdown");
    a_low_power_entry: assert property (power_state == st_active &&
        !shutdown_request && link_mode_request != mode_active &&
        $past(radio_power_enable, 2) |=> power_state == st_low_power &&
        slow_clock_select && !rf_supply_enable)
        else $error("low power entry wrong");
    a_wake_once: assert property ($rose(wake_event) |->
        power_state == st_active && $past(power_state) == st_low_power &&
        !slow_clock_select ##1 !wake_event)
        else $error("wake pulse wrong");
    a_rf_follow: assert property (stay_active |=>
        rf_tx_power_on == $past(tx_packet_active) &&
        rf_pa_power_on == $past(tx_packet_active) &&
        rf_rx_power_on == $past(rx_packet_active) &&
        rf_pll_power_on == ($past(tx_packet_active) ||
        $past(rx_packet_active)))
        else $error("rf sections do not follow packets");
    a_rf_off_idle: assert property (power_state != st_active |->
        !rf_tx_power_on && !rf_rx_power_on && !rf_pll_power_on &&
        !rf_pa_power_on)
        else $error("rf section on outside active");
endmodule : rcsr_top_checker

bind rcsr_top rcsr_top_checker chk (.*);

`default_nettype wire

// >>> testbench/rcsr_host_model.sv
// behavioural host: power enable, shutdown request, slow oscillator
`timescale 1ns/1ps
`default_nettype none

module rcsr_host_model
#(
    parameter int SLOW_HALF = 305
)
(
    // clock and commands from the bench
    input  wire logic clk,
    input  wire logic want_power,
    input  wire logic want_shutdown,
    // pins towards the radio core
    output var logic  radio_power_enable,
    output var logic  shutdown_request,
    output var logic  slow_clock_input
);
    int slow_count = 0;

    // pins move just after an edge; the oscillator runs free, phase arbitrary
    always @(posedge clk)
    begin
        radio_power_enable <= want_power;
        shutdown_request <= want_shutdown;
        slow_count <= (slow_count == 2 * SLOW_HALF - 1) ? 0 : slow_count + 1;
        slow_clock_input <= slow_count >= SLOW_HALF;
    end
endmodule : rcsr_host_model

`default_nettype wire

// >>> testbench/rcsr_top_bench.sv
// self-checking bench for the radio power and reset sequencer
`timescale 1ns/1ps
`default_nettype none

module rcsr_top_bench;
    import rcsr_pkg::*;

    // stimulus, pins and counters
    logic               clk = 1'h0;
    logic               reset = 1'h1;
    logic               want_power = 1'h0;
    logic               want_shutdown = 1'h0;
    logic               io_supply = 1'h1;
    logic               tx_packet_active = 1'h0;
    logic               rx_packet_active = 1'h0;
    rcsr_link_mode_type link_mode_request = mode_active;
    logic [15:0]        wake_interval = 16'h0003;
    logic               radio_power_enable, shutdown_request;
    logic               slow_clock_input, core_reset, core_supply_enable;
    logic               rf_supply_enable, core_clock_enable;
    logic               slow_clock_select, wake_event;
    logic               pins_output_enable_n, pins_input_enable;
    logic               rf_tx_power_on, rf_rx_power_on;
    logic               rf_pll_power_on, rf_pa_power_on;
    rcsr_state_type     power_state;
    int                 bad_count = 0;
    int                 n_checks = 0;
    int                 n;
    // packet rows: tx, rx, then expected tx, rx, pll, pa enables
    logic [5:0]         rows [4] = '{6'h00, 6'h2b, 6'h16, 6'h3f};
    rcsr_link_mode_type modes [3] = '{mode_sniff, mode_hold, mode_park};
    wire logic [7:0]    status_bits = {core_reset, core_supply_enable,
        rf_supply_enable, pins_output_enable_n, pins_input_enable,
        core_clock_enable, slow_clock_select, wake_event};
    wire logic [3:0]    rf_bits = {rf_tx_power_on, rf_rx_power_on,
        rf_pll_power_on, rf_pa_power_on};

    always #25 clk = ~clk;

    rcsr_host_model host (.*);
    rcsr_top dut (.*);

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // bounded wait for a state; n ends as the number of edges taken
    task automatic wait_state(input rcsr_state_type s, input int bound);
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (power_state !== s && n < bound);
        check(16'(power_state), 16'(s));
        if (power_state !== s)
            stop_test();
    endtask : wait_state

    task automatic check_image();
        check(16'(status_bits), 16'h0090);
        check(16'(rf_bits), 16'h0000);
        check(16'(power_state), 16'(st_por_hold));
    endtask : check_image

    // power down, then up; the release edge is counted
    task automatic power_up();
        @(posedge clk);
        want_power <= 1'h0;
        repeat (6) @(posedge clk);
        #1 check(16'(core_reset), 16'h0001);
        check(16'(power_state), 16'(st_por_hold));
        @(posedge clk);
        want_power <= 1'h1;
        @(posedge clk);
        wait_state(st_active, 40);
        check(16'(n), 16'h0007);
        check(16'(status_bits), 16'h006c);
    endtask : power_up

    initial
    begin
        repeat (3) @(posedge clk);
        #1 check_image();
        @(posedge clk);
        reset <= 1'h0;
        power_up();
        // packet rows; the last leaves both windows open
        foreach (rows[i])
        begin
            @(posedge clk);
            {tx_packet_active, rx_packet_active} <= rows[i][5:4];
            repeat (2) @(posedge clk);
            #1 check(16'(rf_bits), 16'(rows[i][3:0]));
        end
        // each mode sleeps three slow ticks; oscillator phase is free
        foreach (modes[i])
        begin
            @(posedge clk);
            link_mode_request <= modes[i];
            wait_state(st_low_power, 3);
            check(16'(status_bits & 8'ha6), 16'h0002);
            wait_state(st_active, 4000);
            check(16'(wake_event), 16'h0001);
            check(16'(n >= 1200 && n <= 1900), 16'h0001);
            @(posedge clk);
            link_mode_request <= mode_active;
            wait_state(st_active, 3);
        end
        // shutdown with packets pending, io supply dropped meanwhile
        @(posedge clk);
        want_shutdown <= 1'h1;
        wait_state(st_shutdown, 4);
        @(posedge clk);
        io_supply <= 1'h0;
        @(posedge clk);
        #1 check(16'(status_bits), 16'h0090);
        check(16'(rf_bits), 16'h0000);
        // shutdown exit is a full power-up
        @(posedge clk);
        io_supply <= 1'h1;
        want_shutdown <= 1'h0;
        wait_state(st_por_hold, 4);
        wait_state(st_active, 8);
        check(16'(n), 16'h0005);
        check(16'(status_bits), 16'h006c);
        // second reset in mid-run with the enable still high
        @(posedge clk);
        reset <= 1'h1;
        @(posedge clk);
        #1 check_image();
        @(posedge clk);
        reset <= 1'h0;
        power_up();
        stop_test();
    end
endmodule : rcsr_top_bench

`default_nettype wire
